// ==== design/cdr_cfg.svh ====
// Offsets, reset values, write masks and bus identities of the control register bank.
`ifndef CDR_CFG_SVH
`define CDR_CFG_SVH
`define CDR_ID_WR   8'h60
`define CDR_ID_RD   8'h61
`define CDR_O_BANK  8'hff
`define CDR_BANK_DSP 8'h00
`define CDR_BANK_SNS 8'h01
`define CDR_BANK_RST 8'h00
`define CDR_NREG    21
`define CDR_NFX     16
`define CDR_O_BYP   8'h05
`define CDR_O_QS    8'h44
`define CDR_O_ICTL  8'h50
`define CDR_O_WW    8'h51
`define CDR_O_WH    8'h52
`define CDR_O_WX    8'h53
`define CDR_O_WY    8'h54
`define CDR_O_WHI   8'h55
`define CDR_O_PICK  8'h56
`define CDR_O_W9    8'h57
`define CDR_O_ZW    8'h5a
`define CDR_O_ZH    8'h5b
`define CDR_O_ZHS   8'h5c
`define CDR_O_FXA   8'h7c
`define CDR_O_FXD   8'h7d
`define CDR_O_MEA   8'h86
`define CDR_O_MEB   8'h87
`define CDR_O_ISZ   8'h8c
`define CDR_O_IW    8'hc0
`define CDR_O_IH    8'hc1
`define CDR_O_MEC   8'hc2
`define CDR_O_MED   8'hc3
`define CDR_D_BYP   8'h01
`define CDR_D_QS    8'h0c
`define CDR_D_WW    8'h40
`define CDR_D_WH    8'hf0
`define CDR_D_WHI   8'h08
`define CDR_D_ZW    8'h58
`define CDR_D_ZH    8'h48
`define CDR_D_MEA   8'h0d
`define CDR_D_MEB   8'h50
`define CDR_D_IW    8'h80
`define CDR_D_IH    8'h60
`define CDR_D_MEC   8'h0c
`define CDR_D_MED   8'hff
`define CDR_D_ZERO  8'h00
`define CDR_M_ALL   8'hff
`define CDR_M_BYP   8'h01
`define CDR_M_W9    8'h80
`define CDR_M_ZHS   8'hf7
`define CDR_M_FXA   8'h0f
`define CDR_M_MEA   8'h3d
`define CDR_M_MEB   8'hc0
`define CDR_M_ISZ   8'h7f
`endif

// ==== design/cdr_pkg.sv ====
// Types shared by the control register bank files.
`default_nettype none

package cdr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_DEVID   = 4'h1,
    ST_ACK_DEV = 4'h3,
    ST_SUBADR  = 4'h2,
    ST_ACK_SUB = 4'h6,
    ST_WDATA   = 4'h7,
    ST_ACK_WR  = 4'h5,
    ST_RDATA   = 4'h4,
    ST_MACK    = 4'hc
  } cdr_st_e;

  typedef struct packed {
    logic       low_power_datapath;
    logic       round;
    logic [2:0] v_div;
    logic [2:0] h_div;
  } cdr_ictl_s;

  typedef struct packed {
    logic exposure_ctrl_enable;
    logic exposure_ctrl_select;
    logic stat_select;
    logic vertical_first;
    logic chroma_422;
    logic luma_chroma_out_enable;
    logic rgb_out_enable;
    logic raw_out_enable;
  } cdr_mec_s;

  typedef struct packed {
    logic color_interp_enable;
    logic dummy_pixel_enable;
    logic unprocessed_gamma_enable;
    logic digital_gain_enable;
    logic white_balance_enable;
    logic white_balance_gain_enable;
    logic lens_correction_enable;
    logic front_stage_enable;
  } cdr_med_s;

  typedef struct packed {
    logic        dsp_bypass;
    logic [7:0]  quant_scale;
    cdr_ictl_s   ictl;
    logic [9:0]  win_w;
    logic [8:0]  win_h;
    logic [10:0] win_x;
    logic [10:0] win_y;
    logic [3:0]  vertical_pick;
    logic [3:0]  horizontal_pick;
    logic [9:0]  zoom_output_width;
    logic [8:0]  zoom_output_height;
    logic [3:0]  zoom_rate;
    logic        downsize_enable;
    logic        special_effects;
    logic        chroma_adjust_enable;
    logic        chroma_average_enable;
    logic        color_matrix_enable;
    logic        black_pixel_correct;
    logic        white_pixel_correct;
    logic [11:0] image_width;
    logic [10:0] image_height;
    cdr_mec_s    mec;
    cdr_med_s    med;
  } cdr_ctl_s;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cdr_sns_s;

endpackage

`default_nettype wire

// ==== design/cdr_pin_sync.sv ====
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`default_nettype none

module cdr_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  for (genvar g = 0; g < W; g++)
  begin : g_bit
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        s1[g]   <= 1'b1;
        s2[g]   <= 1'b1;
        s3[g]   <= 1'b1;
        dout[g] <= 1'b1;
      end
      else
      begin
        s1[g] <= din[g];
        s2[g] <= s1[g];
        s3[g] <= s2[g];
        if (s2[g] == s3[g])
        begin
          dout[g] <= s3[g];
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== design/cdr_fx_regs.sv ====
// Special-effect register file reached through the indirect address and data port.
`include "cdr_cfg.svh"
`default_nettype none

module cdr_fx_regs (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           clr,
  input  wire logic           we,
  input  wire logic [3:0]     idx,
  input  wire logic [7:0]     wd,
  output logic [7:0]          rd,
  output logic [8*`CDR_NFX-1:0] vals
);

  logic [7:0] mem [`CDR_NFX];

  for (genvar g = 0; g < `CDR_NFX; g++)
  begin : g_ent
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        mem[g] <= `CDR_D_ZERO;
      end
      else if (clr)
      begin
        mem[g] <= `CDR_D_ZERO;
      end
      else if (we && idx == 4'(g))
      begin
        mem[g] <= wd;
      end
    end
    assign vals[8*g +: 8] = mem[g];
  end

  assign rd = mem[idx];

endmodule

`default_nettype wire

// ==== design/cdr_dsp_regs.sv ====
// Processor-bank control registers behind the two-wire serial control port.
`include "cdr_cfg.svh"
`default_nettype none

module cdr_dsp_regs (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         sw_rst,
  input  wire logic         sio_c,
  input  wire logic         sio_d_i,
  output logic              sio_d_o,
  output logic              sio_d_oe,
  input  wire logic [7:0]   sns_rdata,
  output cdr_pkg::cdr_sns_s sns,
  output cdr_pkg::cdr_ctl_s ctl,
  output logic [127:0]      fx_vals
);

  localparam int NREG = `CDR_NREG;

  localparam logic [7:0] OFFS [NREG] = '{
    `CDR_O_BYP, `CDR_O_QS, `CDR_O_ICTL, `CDR_O_WW, `CDR_O_WH, `CDR_O_WX, `CDR_O_WY,
    `CDR_O_WHI, `CDR_O_PICK, `CDR_O_W9, `CDR_O_ZW, `CDR_O_ZH, `CDR_O_ZHS, `CDR_O_FXA,
    `CDR_O_MEA, `CDR_O_MEB, `CDR_O_ISZ, `CDR_O_IW, `CDR_O_IH, `CDR_O_MEC, `CDR_O_MED};

  localparam logic [7:0] DEFS [NREG] = '{
    `CDR_D_BYP, `CDR_D_QS, `CDR_D_ZERO, `CDR_D_WW, `CDR_D_WH, `CDR_D_ZERO, `CDR_D_ZERO,
    `CDR_D_WHI, `CDR_D_ZERO, `CDR_D_ZERO, `CDR_D_ZW, `CDR_D_ZH, `CDR_D_ZERO, `CDR_D_ZERO,
    `CDR_D_MEA, `CDR_D_MEB, `CDR_D_ZERO, `CDR_D_IW, `CDR_D_IH, `CDR_D_MEC, `CDR_D_MED};

  localparam logic [7:0] MSKS [NREG] = '{
    `CDR_M_BYP, `CDR_M_ALL, `CDR_M_ALL, `CDR_M_ALL, `CDR_M_ALL, `CDR_M_ALL, `CDR_M_ALL,
    `CDR_M_ALL, `CDR_M_ALL, `CDR_M_W9, `CDR_M_ALL, `CDR_M_ALL, `CDR_M_ZHS, `CDR_M_FXA,
    `CDR_M_MEA, `CDR_M_MEB, `CDR_M_ISZ, `CDR_M_ALL, `CDR_M_ALL, `CDR_M_ALL, `CDR_M_ALL};

  function automatic int ix(input logic [7:0] o);
    int r;
    r = 0;
    for (int i = 0; i < NREG; i++)
    begin
      if (OFFS[i] == o)
      begin
        r = i;
      end
    end
    return r;
  endfunction

  logic [1:0]       pin_f;
  logic             scl;
  logic             sda;
  logic             scl_q;
  logic             sda_q;
  logic             scl_r;
  logic             scl_f;
  logic             start;
  logic             stop;
  cdr_pkg::cdr_st_e st;
  logic [3:0]       cnt;
  logic [7:0]       sh;
  logic [7:0]       tx;
  logic [7:0]       addr;
  logic             rd_dir;
  logic             m_ack;
  logic             byte_end;
  logic             id_hit;
  logic             rx_st;
  logic             load_rd;
  logic             wr;
  logic             dsp_wr;
  logic [7:0]       bank;
  logic [7:0]       regs [NREG];
  logic [7:0]       rd_val;
  logic             hit;
  logic [7:0]       fx_rd;
  logic             sns_wr;
  logic [7:0]       sns_wd;

  cdr_pin_sync #(
    .W (2)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({sio_c, sio_d_i}),
    .dout  (pin_f)
  );

  assign scl = pin_f[1];
  assign sda = pin_f[0];

  // Bus events seen on the filtered clock and data lines.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign scl_r    = scl & ~scl_q;
  assign scl_f    = ~scl & scl_q;
  assign start    = scl & scl_q & sda_q & ~sda;
  assign stop     = scl & scl_q & ~sda_q & sda;
  assign byte_end = scl_f && (cnt == 4'h8);
  assign id_hit   = (sh == `CDR_ID_WR) || (sh == `CDR_ID_RD);
  assign rx_st    = (st == cdr_pkg::ST_DEVID) || (st == cdr_pkg::ST_SUBADR) || (st == cdr_pkg::ST_WDATA);
  assign load_rd  = scl_f && (((st == cdr_pkg::ST_ACK_DEV) && rd_dir) || ((st == cdr_pkg::ST_MACK) && m_ack));
  assign wr       = (st == cdr_pkg::ST_WDATA) && byte_end;
  assign dsp_wr   = wr && (bank == `CDR_BANK_DSP) && (addr != `CDR_O_BANK);

  // Transfer sequencer.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= cdr_pkg::ST_IDLE;
    end
    else if (stop)
    begin
      st <= cdr_pkg::ST_IDLE;
    end
    else if (start)
    begin
      st <= cdr_pkg::ST_DEVID;
    end
    else
    begin
      case (st)
        cdr_pkg::ST_DEVID:   if (byte_end) st <= id_hit ? cdr_pkg::ST_ACK_DEV : cdr_pkg::ST_IDLE;
        cdr_pkg::ST_ACK_DEV: if (scl_f) st <= rd_dir ? cdr_pkg::ST_RDATA : cdr_pkg::ST_SUBADR;
        cdr_pkg::ST_SUBADR:  if (byte_end) st <= cdr_pkg::ST_ACK_SUB;
        cdr_pkg::ST_ACK_SUB: if (scl_f) st <= cdr_pkg::ST_WDATA;
        cdr_pkg::ST_WDATA:   if (byte_end) st <= cdr_pkg::ST_ACK_WR;
        cdr_pkg::ST_ACK_WR:  if (scl_f) st <= cdr_pkg::ST_WDATA;
        cdr_pkg::ST_RDATA:   if (byte_end) st <= cdr_pkg::ST_MACK;
        cdr_pkg::ST_MACK:    if (scl_f) st <= m_ack ? cdr_pkg::ST_RDATA : cdr_pkg::ST_IDLE;
        default:             st <= cdr_pkg::ST_IDLE;
      endcase
    end
  end

  // Bit counter and receive shifter.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 4'h0;
      sh  <= 8'h00;
    end
    else if (start || stop)
    begin
      cnt <= 4'h0;
    end
    else if (load_rd)
    begin
      cnt <= 4'h1;
    end
    else if (scl_f && !rx_st && (st != cdr_pkg::ST_RDATA))
    begin
      cnt <= 4'h0;
    end
    else if (rx_st && scl_r && (cnt != 4'h8))
    begin
      sh  <= {sh[6:0], sda};
      cnt <= cnt + 4'h1;
    end
    else if ((st == cdr_pkg::ST_RDATA) && scl_f && (cnt != 4'h8))
    begin
      cnt <= cnt + 4'h1;
    end
  end

  // Direction of the transfer and the master's answer after a read byte.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_dir <= 1'b0;
      m_ack  <= 1'b0;
    end
    else
    begin
      if ((st == cdr_pkg::ST_DEVID) && byte_end)
      begin
        rd_dir <= (sh == `CDR_ID_RD);
      end
      if ((st == cdr_pkg::ST_MACK) && scl_r)
      begin
        m_ack <= ~sda;
      end
    end
  end

  // Register pointer, advanced after each data byte.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr <= 8'h00;
    end
    else if ((st == cdr_pkg::ST_SUBADR) && byte_end)
    begin
      addr <= sh;
    end
    else if (wr || ((st == cdr_pkg::ST_RDATA) && byte_end))
    begin
      addr <= addr + 8'h1;
    end
  end

  // Read shifter, most significant bit first.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx <= 8'h00;
    end
    else if (load_rd)
    begin
      tx <= {rd_val[6:0], 1'b0};
    end
    else if ((st == cdr_pkg::ST_RDATA) && scl_f)
    begin
      tx <= {tx[6:0], 1'b0};
    end
  end

  // Data line driver; the pin is only ever pulled low.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sio_d_oe <= 1'b0;
      sio_d_o  <= 1'b0;
    end
    else if (start || stop)
    begin
      sio_d_oe <= 1'b0;
    end
    else if (byte_end && rx_st)
    begin
      sio_d_oe <= (st != cdr_pkg::ST_DEVID) || id_hit;
    end
    else if (load_rd)
    begin
      sio_d_oe <= ~rd_val[7];
    end
    else if (scl_f && (st == cdr_pkg::ST_RDATA))
    begin
      sio_d_oe <= byte_end ? 1'b0 : ~tx[7];
    end
    else if (scl_f)
    begin
      sio_d_oe <= 1'b0;
    end
  end

  // Bank selector, reachable from either bank.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bank <= `CDR_BANK_RST;
    end
    else if (sw_rst)
    begin
      bank <= `CDR_BANK_RST;
    end
    else if (wr && (addr == `CDR_O_BANK))
    begin
      bank <= sh;
    end
  end

  // Processor-bank registers; writes never store reserved bits, but reset loads bit 4 at offset 0x87.
  for (genvar g = 0; g < NREG; g++)
  begin : g_reg
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        regs[g] <= DEFS[g];
      end
      else if (sw_rst)
      begin
        regs[g] <= DEFS[g];
      end
      else if (dsp_wr && (addr == OFFS[g]))
      begin
        regs[g] <= sh & MSKS[g];
      end
    end
  end

  cdr_fx_regs u_fx (
    .clk   (clk),
    .rst_b (rst_b),
    .clr   (sw_rst),
    .we    (dsp_wr && (addr == `CDR_O_FXD)),
    .idx   (regs[ix(`CDR_O_FXA)][3:0]),
    .wd    (sh),
    .rd    (fx_rd),
    .vals  (fx_vals)
  );

  // Sensor-bank accesses are passed out to the sensor register file.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sns_wr <= 1'b0;
      sns_wd <= 8'h00;
    end
    else
    begin
      sns_wr <= wr && (bank == `CDR_BANK_SNS) && (addr != `CDR_O_BANK);
      sns_wd <= sh;
    end
  end

  assign sns = '{wr: sns_wr, addr: addr, wdata: sns_wd};

  // Read selection for the byte about to be shifted out.
  always_comb
  begin
    rd_val = 8'h00;
    hit    = 1'b0;
    if (addr == `CDR_O_BANK)
    begin
      rd_val = bank;
    end
    else if (bank == `CDR_BANK_SNS)
    begin
      rd_val = sns_rdata;
    end
    else if (bank == `CDR_BANK_DSP)
    begin
      if (addr == `CDR_O_FXD)
      begin
        rd_val = fx_rd;
        hit    = 1'b1;
      end
      for (int i = 0; i < NREG; i++)
      begin
        if (addr == OFFS[i])
        begin
          rd_val = regs[i];
          hit    = 1'b1;
        end
      end
    end
  end

  // Fields handed to the image datapath.
  assign ctl.dsp_bypass            = regs[ix(`CDR_O_BYP)][0];
  assign ctl.quant_scale           = regs[ix(`CDR_O_QS)];
  assign ctl.ictl                  = regs[ix(`CDR_O_ICTL)];
  assign ctl.win_w                 = {regs[ix(`CDR_O_W9)][7], regs[ix(`CDR_O_WHI)][3], regs[ix(`CDR_O_WW)]};
  assign ctl.win_h                 = {regs[ix(`CDR_O_WHI)][7], regs[ix(`CDR_O_WH)]};
  assign ctl.win_x                 = {regs[ix(`CDR_O_WHI)][2:0], regs[ix(`CDR_O_WX)]};
  assign ctl.win_y                 = {regs[ix(`CDR_O_WHI)][6:4], regs[ix(`CDR_O_WY)]};
  assign ctl.vertical_pick         = regs[ix(`CDR_O_PICK)][7:4];
  assign ctl.horizontal_pick       = regs[ix(`CDR_O_PICK)][3:0];
  assign ctl.zoom_output_width     = {regs[ix(`CDR_O_ZHS)][1:0], regs[ix(`CDR_O_ZW)]};
  assign ctl.zoom_output_height    = {regs[ix(`CDR_O_ZHS)][2], regs[ix(`CDR_O_ZH)]};
  assign ctl.zoom_rate             = regs[ix(`CDR_O_ZHS)][7:4];
  assign ctl.downsize_enable       = regs[ix(`CDR_O_MEA)][5];
  assign ctl.special_effects       = regs[ix(`CDR_O_MEA)][4];
  assign ctl.chroma_adjust_enable  = regs[ix(`CDR_O_MEA)][3];
  assign ctl.chroma_average_enable = regs[ix(`CDR_O_MEA)][2];
  assign ctl.color_matrix_enable   = regs[ix(`CDR_O_MEA)][0];
  assign ctl.black_pixel_correct   = regs[ix(`CDR_O_MEB)][7];
  assign ctl.white_pixel_correct   = regs[ix(`CDR_O_MEB)][6];
  assign ctl.image_width           = {regs[ix(`CDR_O_ISZ)][6], regs[ix(`CDR_O_IW)], regs[ix(`CDR_O_ISZ)][5:3]};
  assign ctl.image_height          = {regs[ix(`CDR_O_IH)], regs[ix(`CDR_O_ISZ)][2:0]};
  assign ctl.mec                   = regs[ix(`CDR_O_MEC)];
  assign ctl.med                   = regs[ix(`CDR_O_MED)];

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_b);

  id_ack_a: assert property (
    (st == cdr_pkg::ST_DEVID) && byte_end && id_hit |=> (st == cdr_pkg::ST_ACK_DEV) && sio_d_oe)
    else $error("Own identity was not acknowledged.");

  id_miss_a: assert property (
    (st == cdr_pkg::ST_DEVID) && byte_end && !id_hit |=> (st == cdr_pkg::ST_IDLE) && !sio_d_oe)
    else $error("Foreign identity was answered.");

  ack_hold_a: assert property (
    (st == cdr_pkg::ST_ACK_SUB) && !scl_f |=> sio_d_oe || start || stop || $past(start || stop))
    else $error("Offset acknowledge released early.");

  read_bit_a: assert property (
    (st == cdr_pkg::ST_RDATA) && scl_f && (cnt != 4'h8) && !start && !stop |=> sio_d_oe == !$past(tx[7]))
    else $error("Read bit driven wrongly.");

  bank_load_a: assert property (
    wr && (addr == `CDR_O_BANK) && !sw_rst |=> bank == $past(sh))
    else $error("Bank selector did not load.");

  sensor_route_a: assert property (
    wr && (bank == `CDR_BANK_SNS) && (addr != `CDR_O_BANK) |=> sns.wr && (sns.wdata == $past(sh)))
    else $error("Sensor bank write not passed out.");

  bypass_write_a: assert property (
    dsp_wr && (addr == `CDR_O_BYP) && !sw_rst |=> ctl.dsp_bypass == $past(sh[0]))
    else $error("Bypass bit did not follow write.");

  fx_write_a: assert property (
    dsp_wr && (addr == `CDR_O_FXD) && !sw_rst |=> fx_rd == $past(sh))
    else $error("Effect register write lost.");

  size_low_a: assert property (
    dsp_wr && (addr == `CDR_O_ISZ) && !sw_rst |=>
      (ctl.image_width[2:0] == $past(sh[5:3])) && (ctl.image_height[2:0] == $past(sh[2:0])))
    else $error("Image size low bits misplaced.");

  rsvd_read_a: assert property (
    (bank == `CDR_BANK_DSP) && (addr != `CDR_O_BANK) && !hit |-> rd_val == 8'h00)
    else $error("Reserved offset read non-zero.");

  sw_default_a: assert property (
    sw_rst |=> (regs[ix(`CDR_O_MEA)] == `CDR_D_MEA) && (regs[ix(`CDR_O_MED)] == `CDR_D_MED) && ctl.dsp_bypass)
    else $error("Software reset missed defaults.");

endmodule

`default_nettype wire

// ==== bench/cdr_host.sv ====
// Host controller model that drives the two-wire control port.
`default_nettype none

module cdr_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic settle();
    tick(10000);
  endtask

  task automatic start();
    pull <= 1'b0;
    tick(11);
    scl <= 1'b1;
    tick(6);
    pull <= 1'b1;
    tick(6);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic stop();
    pull <= 1'b1;
    tick(11);
    scl <= 1'b1;
    tick(6);
    pull <= 1'b0;
    tick(13);
  endtask

  task automatic clock_bit(input logic b, output logic s);
    pull <= ~b;
    tick(11);
    scl <= 1'b1;
    tick(6);
    s = sda;
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(tx[i], rx[i]);
    clock_bit(mack, s);
    ack = ~s;
  endtask

  task automatic wr(input logic [7:0] o, input logic [7:0] v, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer(8'h60, 1'b1, r, a0);
    xfer(o, 1'b1, r, a1);
    xfer(v, 1'b1, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  task automatic rd(input logic [7:0] o, output logic [7:0] v, output logic ok);
    logic [7:0] r;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       n;
    start();
    xfer(8'h60, 1'b1, r, a0);
    xfer(o, 1'b1, r, a1);
    stop();
    start();
    xfer(8'h61, 1'b1, r, a2);
    xfer(8'hff, 1'b1, v, n);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the processor-bank control registers.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk = 1'b0;
  logic              rst_b;
  logic              sw_rst;
  logic              scl;
  logic              pull;
  wire               sda;
  logic              sio_d_o;
  logic              sio_d_oe;
  wire [7:0]         sns_rdata;
  cdr_pkg::cdr_sns_s sns;
  cdr_pkg::cdr_ctl_s ctl;
  logic [127:0]      fx_vals;
  int                error_cnt;
  int                n_compared;
  int                sns_wr_cnt;
  logic [7:0]        sns_wd;
  logic [7:0]        sns_ad;
  logic [7:0]        d;
  logic              ok;
  logic [7:0]        p [256];
  logic [7:0]        ofs [22] = '{8'h05,8'h44,8'h50,8'h51,8'h52,8'h53,8'h54,8'h55,8'h56,8'h57,8'h5a,
                                  8'h5b,8'h5c,8'h7c,8'h7d,8'h86,8'h87,8'h8c,8'hc0,8'hc1,8'hc2,8'hc3};
  logic [7:0]        dfl [22] = '{8'h01,8'h0c,8'h00,8'h40,8'hf0,8'h00,8'h00,8'h08,8'h00,8'h00,8'h58,
                                  8'h48,8'h00,8'h00,8'h00,8'h0d,8'h50,8'h00,8'h80,8'h60,8'h0c,8'hff};
  logic [7:0]        msk [22] = '{8'h01,8'hff,8'hff,8'hff,8'hff,8'hff,8'hff,8'hff,8'hff,8'h80,8'hff,
                                  8'hff,8'hf7,8'h0f,8'hff,8'h3d,8'hc0,8'h7f,8'hff,8'hff,8'hff,8'hff};

  always #50 clk = ~clk;

  assign sda = ~(pull | sio_d_oe);
  assign sns_rdata = sns.addr ^ 8'hc3;

  cdr_dsp_regs u_cdr_dsp_regs (
    .clk       (clk),
    .rst_b     (rst_b),
    .sw_rst    (sw_rst),
    .sio_c     (scl),
    .sio_d_i   (sda),
    .sio_d_o   (sio_d_o),
    .sio_d_oe  (sio_d_oe),
    .sns_rdata (sns_rdata),
    .sns       (sns),
    .ctl       (ctl),
    .fx_vals   (fx_vals)
  );

  cdr_host u_cdr_host (
    .clk  (clk),
    .sda  (sda),
    .scl  (scl),
    .pull (pull)
  );

  always @(posedge clk)
  begin
    if (sns.wr === 1'b1)
    begin
      sns_wr_cnt++;
      sns_wd = sns.wdata;
      sns_ad = sns.addr;
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic w(input logic [7:0] o, input logic [7:0] v);
    logic a;
    u_cdr_host.wr(o, v, a);
    chk("write ack", 32'h1, 32'(a));
  endtask

  task automatic rc(input string nm, input logic [7:0] o, input logic [7:0] e);
    logic a;
    logic [7:0] v;
    u_cdr_host.rd(o, v, a);
    chk("read ack", 32'h1, 32'(a));
    chk(nm, 32'(e), 32'(v));
  endtask

  task automatic dflt();
    for (int i = 0; i < 22; i++)
      rc("default", ofs[i], dfl[i]);
  endtask

  task automatic results();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (98000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial
  begin
    rst_b = 1'b0;
    sw_rst = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    sns_wr_cnt = 0;
    for (int i = 0; i < 256; i++)
      p[i] = 8'(i) ^ 8'h69;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    u_cdr_host.settle();
    dflt();
    for (int i = 0; i < 22; i++)
      w(ofs[i], p[ofs[i]]);
    for (int i = 0; i < 22; i++)
      rc("readback", ofs[i], p[ofs[i]] & msk[i]);
    chk("ctl a", 32'({p[8'h50], p[8'h05][0], p[8'h44]}), 32'({ctl.ictl, ctl.dsp_bypass, ctl.quant_scale}));
    chk("win size", 32'({p[8'h57][7], p[8'h55][3], p[8'h51], p[8'h55][7], p[8'h52]}),
        32'({ctl.win_w, ctl.win_h}));
    chk("win offs", 32'({p[8'h55][2:0], p[8'h53], p[8'h55][6:4], p[8'h54]}), 32'({ctl.win_x, ctl.win_y}));
    chk("zoom", 32'({p[8'h56], p[8'h5c][1:0], p[8'h5a], p[8'h5c][2], p[8'h5b], p[8'h5c][7:4]}),
        32'({ctl.vertical_pick, ctl.horizontal_pick, ctl.zoom_output_width, ctl.zoom_output_height, ctl.zoom_rate}));
    chk("enables", 32'({p[8'h86][5:2], p[8'h86][0], p[8'h87][7:6], p[8'hc2], p[8'hc3]}),
        32'({ctl.downsize_enable, ctl.special_effects, ctl.chroma_adjust_enable, ctl.chroma_average_enable,
             ctl.color_matrix_enable, ctl.black_pixel_correct, ctl.white_pixel_correct, ctl.mec, ctl.med}));
    chk("image", 32'({p[8'h8c][6], p[8'hc0], p[8'h8c][5:3], p[8'hc1], p[8'h8c][2:0]}),
        32'({ctl.image_width, ctl.image_height}));
    chk("fx pattern", 32'(p[8'h7d]), 32'(fx_vals[47:40]));
    w(8'h06, 8'hff);
    rc("reserved", 8'h06, 8'h00);
    u_cdr_host.start();
    u_cdr_host.xfer(8'h62, 1'b1, d, ok);
    u_cdr_host.stop();
    chk("foreign id", 32'h0, 32'(ok));
    w(8'h7c, 8'h03);
    w(8'h7d, 8'hab);
    w(8'h7c, 8'h0c);
    w(8'h7d, 8'hcd);
    chk("fx", 32'h0000cdab, 32'({fx_vals[103:96], fx_vals[31:24]}));
    w(8'h7c, 8'h03);
    rc("fx data", 8'h7d, 8'hab);
    w(8'hff, 8'h01);
    w(8'h05, 8'ha5);
    rc("sensor read", 8'h20, 8'he3);
    rc("bank", 8'hff, 8'h01);
    w(8'hff, 8'h02);
    w(8'h05, 8'ha5);
    rc("no bank", 8'h05, 8'h00);
    chk("sensor write", 32'h000001a5, {15'h0, ctl.dsp_bypass, 8'(sns_wr_cnt), sns_wd});
    chk("sensor addr", 32'h06, 32'(sns_ad));
    chk("data out", 32'h0, 32'(sio_d_o));
    sw_rst <= 1'b1;
    @(posedge clk);
    sw_rst <= 1'b0;
    dflt();
    chk("fx clear", 32'h0, fx_vals[31:0]);
    results();
  end
endmodule

`default_nettype wire
